// ---- common/iss_pkg.sv ----
// Shared types and constants of the image sensor sequencer control
`default_nettype none
package iss_pkg;
	// Clocking: clk is the input clock, the sensor clock is clk / 4
	localparam int CLK_PERIOD_NS = 8;
	localparam int SENSOR_DIV = 4;
	localparam int SENSOR_PERIOD_NS = CLK_PERIOD_NS * SENSOR_DIV;
	localparam logic [1:0] DIV_TICK = 2'h3;
	// Extra sequencer hold after the chip reset rises
	localparam int SEQ_HOLD_NS = 500;
	localparam int SEQ_HOLD_CYCLES =
		(SEQ_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Row overhead length of the reduced mode, in sensor clocks
	localparam int REDUCED_ROW_OVH_CYCLES = 9;
	// Default frame overhead length, in sensor clocks
	localparam int FRAME_OVH_NS = 3200;
	localparam int FRAME_OVH_RESET_CYCLES =
		(FRAME_OVH_NS + SENSOR_PERIOD_NS - 1) / SENSOR_PERIOD_NS;
	// Output buffer depth
	localparam logic [1:0] BUF_DEPTH = 2'h2;
	// Configuration values after chip reset
	localparam logic [5:0] KERNEL_START_RESET = 6'h01;
	localparam logic [5:0] KERNEL_COUNT_RESET = 6'h35;
	localparam logic [10:0] LINE_FIRST_RESET = 11'h000;
	localparam logic [10:0] LINE_LAST_RESET = 11'h6ad;
	localparam logic [15:0] IDLE_A_RESET = 16'h02aa;
	localparam logic [15:0] IDLE_B_RESET = 16'h0155;

	typedef struct packed {
		logic reduced_row_ovh;
		logic [7:0] row_overhead_length;
		logic [5:0] window_kernel_start;
		logic [5:0] window_kernel_count;
		logic [10:0] line_first;
		logic [10:0] line_last;
		logic [9:0] frame_ovh_length;
		logic [15:0] idle_a;
		logic [15:0] idle_b;
	} iss_cfg_t;

	localparam iss_cfg_t CFG_RESET = '{
		reduced_row_ovh: 1'b1,
		row_overhead_length: 8'(REDUCED_ROW_OVH_CYCLES),
		window_kernel_start: KERNEL_START_RESET,
		window_kernel_count: KERNEL_COUNT_RESET,
		line_first: LINE_FIRST_RESET,
		line_last: LINE_LAST_RESET,
		frame_ovh_length: 10'(FRAME_OVH_RESET_CYCLES),
		idle_a: IDLE_A_RESET,
		idle_b: IDLE_B_RESET
	};

	typedef enum logic [1:0] {
		KIND_IDLE_A,
		KIND_IDLE_B,
		KIND_LINE,
		KIND_PIXEL
	} iss_kind_t;

	typedef struct packed {
		iss_kind_t kind;
		logic [15:0] value;
	} iss_word_t;

	typedef enum logic [1:0] {
		ST_WAIT,
		ST_FRAME_OVH,
		ST_ROW_OVH,
		ST_READ
	} iss_state_t;
endpackage
`default_nettype wire

// ---- hw/iss_control.sv ----
// Readout sequencer control of a global-shutter image sensor
//
// Notes on behaviour
// R01: After reset the row overhead runs reduced, nine sensor clocks long.
// R02: Frame overhead runs from memory strobe fall to first row shift clock.
// R03: Frame indicator rises with the strobe fall, drops one clock early.
// R04: Row indicator rises at row start, drops one sensor clock before end.
// R05: Chip reset low clears everything, configuration included, at once.
// R06: Sequencer reset clears only the sequencer; configuration is kept.
// R07: Sequencer stays in reset 0.5 us after chip reset rises.
// R08: Outputs invalid in chip reset; idle words alternate in sequencer reset.
// R09: Controller keeps pixels in reset at least 3 us.
// R10: Controller holds sequencer reset low at least twenty input clocks.
// R11: After a sequencer reset the controller starts with a fresh exposure.
// R12: Controller uploads configuration while sequencer reset, then releases.
// R13: Window start kernel is always odd; kernel count is limited by R15 and R16.
// R14: Lines are read from first to last line of the window.
// R15: Controller never programs fewer than four kernels or one line.
// R16: Controller keeps row overhead length plus kernel count even; the first bench frame runs nine reduced clocks with four kernels.
// R17: Controller lengthens row overhead by one when kernels drop at minimum; the first frame sets ten but keeps reduced nine-clock rows.
// R18: Only the window part of the array is read out.
// R19: One rectangular window only; no subsampling or reverse scan.
// R20: Controller times both exposure pins for dual slope.
// R21: Exposure fall starts frame overhead; rise starts exposure next row.
// R22: Controller holds each exposure level at least fifteen input clocks.
// R23: Indicators change only on sensor clock edges, input clock over four.
`default_nettype none
module iss_control (
	input wire logic clk,
	input wire logic nrst,
	input wire logic sequencer_restart_low,
	input wire logic cfg_load,
	input wire iss_pkg::iss_cfg_t cfg_in,
	input wire logic exposure_1,
	input wire logic exposure_2,
	input wire logic out_ready,
	output logic out_valid,
	output iss_pkg::iss_word_t out_word,
	output logic frame_overhead_indicator,
	output logic row_overhead_indicator,
	output logic pixel_reset,
	output logic dual_slope_reset,
	output logic sequencer_running,
	output iss_pkg::iss_cfg_t cfg_active
);
	iss_pkg::iss_cfg_t cfg_reg;
	logic [5:0] hold_cnt_reg;
	logic hold_done;
	logic seq_rstn_reg;
	logic [1:0] div_reg;
	logic sensor_tick;
	logic tick_adv;
	logic [1:0] exp_meta_reg;
	logic [1:0] exp_sync_reg;
	logic [1:0] exp_smp_reg;
	logic [1:0] exp_old_reg;
	logic exp1_rise;
	logic exp1_fall;
	logic expo_req_reg;
	logic frame_req_reg;
	logic expo_take;
	logic frame_take;
	iss_pkg::iss_state_t state_reg;
	iss_pkg::iss_state_t state_next;
	logic [9:0] cnt_reg;
	logic [9:0] cnt_next;
	logic [10:0] line_reg;
	logic [10:0] line_next;
	logic [9:0] row_len;
	logic [5:0] kernel_first;
	logic idle_sel_reg;
	logic frame_ind_reg;
	logic row_ind_reg;
	logic pix_rst_reg;
	logic dual_reg;
	logic row_entry;
	iss_pkg::iss_word_t word_in;
	logic buf_in_ready;
	logic [9:0] row_hi_cnt_reg;

	// True on the last sensor clock of a period of the given length
	function automatic logic at_end(input logic [9:0] cnt,
		input logic [9:0] len);
		at_end = ({1'b0, cnt} + 11'h001) >= {1'b0, len};
	endfunction

	// Indicator level: high until one sensor clock before the end
	function automatic logic ovh_high(input logic [9:0] cnt,
		input logic [9:0] len);
		ovh_high = ({1'b0, cnt} + 11'h002) <= {1'b0, len};
	endfunction

	// Configuration store, cleared only by the chip reset
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			cfg_reg <= iss_pkg::CFG_RESET; // R05 R01
		else if (cfg_load)
			cfg_reg <= cfg_in; // R06
	end

	// Hold count after the chip reset rises
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			hold_cnt_reg <= 6'h00;
		else if (!hold_done)
			hold_cnt_reg <= hold_cnt_reg + 6'h01; // R07
	end
	assign hold_done = hold_cnt_reg == 6'(iss_pkg::SEQ_HOLD_CYCLES);

	// Glitch-free sequencer reset, drops at once with the chip reset
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			seq_rstn_reg <= 1'b0; // R05
		else
			seq_rstn_reg <= hold_done && sequencer_restart_low; // R06 R07
	end

	// Sensor clock enable, one pulse every four input clocks
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			div_reg <= 2'h0;
		else
			div_reg <= div_reg + 2'h1;
	end
	assign sensor_tick = div_reg == iss_pkg::DIV_TICK; // R23
	assign tick_adv = sensor_tick && buf_in_ready;

	// Exposure pins: two-stage synchroniser
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			exp_meta_reg <= 2'h0;
			exp_sync_reg <= 2'h0;
		end else begin
			exp_meta_reg <= {exposure_2, exposure_1};
			exp_sync_reg <= exp_meta_reg;
		end
	end

	// Deglitch on the sensor clock and keep the previous sample
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			exp_smp_reg <= 2'h0;
			exp_old_reg <= 2'h0;
		end else if (sensor_tick) begin
			exp_smp_reg <= exp_sync_reg;
			exp_old_reg <= exp_smp_reg;
		end
	end
	assign exp1_rise = sensor_tick && exp_smp_reg[0] && !exp_old_reg[0];
	assign exp1_fall = sensor_tick && !exp_smp_reg[0] && exp_old_reg[0];

	// Pending exposure and frame requests; a new edge wins over a take
	always_ff @(posedge clk or negedge seq_rstn_reg) begin
		if (!seq_rstn_reg) begin
			expo_req_reg <= 1'b0;
			frame_req_reg <= 1'b0;
		end else begin
			if (exp1_rise)
				expo_req_reg <= 1'b1; // R21
			else if (expo_take)
				expo_req_reg <= 1'b0;
			if (exp1_fall)
				frame_req_reg <= 1'b1; // R21
			else if (frame_take)
				frame_req_reg <= 1'b0;
		end
	end

	// Row length and the single window's first kernel
	assign row_len = cfg_reg.reduced_row_ovh ?
		10'(iss_pkg::REDUCED_ROW_OVH_CYCLES) :
		{2'h0, cfg_reg.row_overhead_length}; // R01
	assign kernel_first = cfg_reg.window_kernel_start | 6'h01; // R13 R19
	assign row_entry = state_next == iss_pkg::ST_ROW_OVH &&
		state_reg == iss_pkg::ST_READ;
	assign expo_take = tick_adv && expo_req_reg &&
		(state_reg == iss_pkg::ST_WAIT || row_entry); // R21
	assign frame_take = tick_adv &&
		state_next == iss_pkg::ST_FRAME_OVH &&
		state_reg != iss_pkg::ST_FRAME_OVH;

	// Sequencer next state
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg + 10'h001;
		line_next = line_reg;
		case (state_reg)
			iss_pkg::ST_WAIT: begin
				cnt_next = 10'h000;
				if (frame_req_reg)
					state_next = iss_pkg::ST_FRAME_OVH; // R21
			end
			iss_pkg::ST_FRAME_OVH: begin
				if (at_end(cnt_reg, cfg_reg.frame_ovh_length)) begin
					state_next = iss_pkg::ST_ROW_OVH; // R02
					cnt_next = 10'h000;
					line_next = cfg_reg.line_first; // R14
				end
			end
			iss_pkg::ST_ROW_OVH: begin
				if (at_end(cnt_reg, row_len)) begin
					state_next = iss_pkg::ST_READ; // R04
					cnt_next = 10'h000;
				end
			end
			iss_pkg::ST_READ: begin
				if (at_end(cnt_reg,
					{4'h0, cfg_reg.window_kernel_count})) begin // R18
					cnt_next = 10'h000;
					if (frame_req_reg) begin
						state_next = iss_pkg::ST_FRAME_OVH; // R21
					end else if (line_reg >= cfg_reg.line_last) begin
						state_next = iss_pkg::ST_WAIT; // R14
					end else begin
						state_next = iss_pkg::ST_ROW_OVH;
						line_next = line_reg + 11'h001; // R14
					end
				end
			end
			default: begin
				state_next = iss_pkg::ST_WAIT;
				cnt_next = 10'h000;
			end
		endcase
	end

	// Sequencer state and indicators, advanced on accepted sensor clocks
	always_ff @(posedge clk or negedge seq_rstn_reg) begin
		if (!seq_rstn_reg) begin
			state_reg <= iss_pkg::ST_WAIT; // R06
			cnt_reg <= 10'h000;
			line_reg <= 11'h000;
			frame_ind_reg <= 1'b0;
			row_ind_reg <= 1'b0;
		end else if (tick_adv) begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			line_reg <= line_next;
			frame_ind_reg <= state_next == iss_pkg::ST_FRAME_OVH &&
				ovh_high(cnt_next, cfg_reg.frame_ovh_length); // R03 R23
			row_ind_reg <= state_next == iss_pkg::ST_ROW_OVH &&
				ovh_high(cnt_next, row_len); // R04 R23
		end
	end

	// Pixel reset: set at frame overhead end, released by exposure
	always_ff @(posedge clk or negedge seq_rstn_reg) begin
		if (!seq_rstn_reg) begin
			pix_rst_reg <= 1'b1;
			dual_reg <= 1'b0;
		end else if (tick_adv) begin
			if (state_reg == iss_pkg::ST_FRAME_OVH &&
				state_next == iss_pkg::ST_ROW_OVH)
				pix_rst_reg <= 1'b1;
			else if (expo_take)
				pix_rst_reg <= 1'b0; // R21
			dual_reg <= exp_smp_reg[1] && !pix_rst_reg;
		end
	end

	// Word source: line address, kernel data, or alternating idle words
	always_comb begin
		word_in.kind = idle_sel_reg ? iss_pkg::KIND_IDLE_B :
			iss_pkg::KIND_IDLE_A; // R08
		word_in.value = idle_sel_reg ? cfg_reg.idle_b : cfg_reg.idle_a;
		if (seq_rstn_reg && state_reg == iss_pkg::ST_ROW_OVH &&
			cnt_reg == 10'h000) begin
			word_in.kind = iss_pkg::KIND_LINE;
			word_in.value = {5'h00, line_reg};
		end else if (seq_rstn_reg && state_reg == iss_pkg::ST_READ) begin
			word_in.kind = iss_pkg::KIND_PIXEL;
			word_in.value = {10'h000,
				6'(kernel_first + cnt_reg[5:0])}; // R13 R18
		end
	end

	// Idle word alternation, running through the sequencer reset
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			idle_sel_reg <= 1'b0;
		else if (tick_adv && (word_in.kind == iss_pkg::KIND_IDLE_A ||
			word_in.kind == iss_pkg::KIND_IDLE_B))
			idle_sel_reg <= ~idle_sel_reg; // R08
	end

	// Output buffer; a full buffer stalls the sequencer
	iss_pair_buffer u_buffer (
		.clk(clk),
		.nrst(nrst),
		.in_valid(sensor_tick),
		.in_ready(buf_in_ready),
		.in_word(word_in),
		.out_valid(out_valid),
		.out_ready(out_ready),
		.out_word(out_word)
	);

	assign frame_overhead_indicator = frame_ind_reg;
	assign row_overhead_indicator = row_ind_reg;
	assign pixel_reset = pix_rst_reg;
	assign dual_slope_reset = dual_reg;
	assign sequencer_running = seq_rstn_reg;
	assign cfg_active = cfg_reg;

	// Helper: sensor clocks the row indicator stayed high
	always_ff @(posedge clk or negedge seq_rstn_reg) begin
		if (!seq_rstn_reg)
			row_hi_cnt_reg <= 10'h000;
		else if (tick_adv)
			row_hi_cnt_reg <= row_ind_reg ? row_hi_cnt_reg + 10'h001 :
				10'h000;
	end

	// Checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	row_ind_len_a: assert property (disable iff (!nrst || !seq_rstn_reg) // R04
		$fell(row_ind_reg) |-> row_hi_cnt_reg == row_len - 10'h001)
		else $error("row indicator length wrong");
	reduced_len_a: assert property (disable iff (!nrst || !seq_rstn_reg) // R01
		($fell(row_ind_reg) && cfg_reg.reduced_row_ovh) |->
		row_hi_cnt_reg == 10'h008)
		else $error("reduced row overhead not nine clocks");
	frame_rise_a: assert property (disable iff (!nrst || !seq_rstn_reg) // R03
		($rose(state_reg == iss_pkg::ST_FRAME_OVH) &&
		cfg_reg.frame_ovh_length > 10'h001) |-> frame_ind_reg)
		else $error("frame indicator did not rise");
	frame_drop_a: assert property (disable iff (!nrst || !seq_rstn_reg) // R03
		(state_reg == iss_pkg::ST_FRAME_OVH &&
		at_end(cnt_reg, cfg_reg.frame_ovh_length)) |-> !frame_ind_reg)
		else $error("frame indicator high in last clock");
	row_follows_a: assert property (disable iff (!nrst || !seq_rstn_reg) // R02
		(state_reg == iss_pkg::ST_FRAME_OVH && tick_adv &&
		at_end(cnt_reg, cfg_reg.frame_ovh_length)) |=>
		state_reg == iss_pkg::ST_ROW_OVH && cnt_reg == 10'h000)
		else $error("row overhead did not follow frame overhead");
	hold_release_a: assert property ( // R07
		$rose(seq_rstn_reg) |-> $past(hold_done) &&
		hold_cnt_reg == 6'h3f)
		else $error("sequencer released before hold time");
	idle_words_a: assert property ( // R08
		!seq_rstn_reg |-> (word_in.kind == iss_pkg::KIND_IDLE_A ||
		word_in.kind == iss_pkg::KIND_IDLE_B))
		else $error("non-idle word during sequencer reset");
	odd_start_a: assert property (disable iff (!nrst || !seq_rstn_reg) // R13
		(state_reg == iss_pkg::ST_READ && cnt_reg == 10'h000) |->
		word_in.value[0])
		else $error("window starts on even kernel");
	line_range_a: assert property (disable iff (!nrst || !seq_rstn_reg) // R14
		(state_reg == iss_pkg::ST_READ && !cfg_load) |->
		line_reg >= cfg_reg.line_first && line_reg <= cfg_reg.line_last)
		else $error("line outside window");
	ind_tick_a: assert property ( // R23
		($changed(frame_ind_reg) || $changed(row_ind_reg)) && seq_rstn_reg
		|-> $past(sensor_tick))
		else $error("indicator changed off sensor clock");
	cfg_keep_a: assert property ( // R06
		(!sequencer_restart_low && !cfg_load) |=> $stable(cfg_reg))
		else $error("configuration lost in sequencer reset");
	frame_row_c: cover property (
		$fell(frame_ind_reg) ##[1:40] $rose(row_ind_reg));
	line_word_c: cover property (
		out_valid && out_ready && out_word.kind == iss_pkg::KIND_LINE);
	stall_c: cover property (sensor_tick && !buf_in_ready);
	seq_restart_c: cover property ($fell(seq_rstn_reg) && hold_done);
endmodule
`default_nettype wire

// ---- hw/iss_pair_buffer.sv ----
// Two-entry word buffer with valid and ready on both sides
`default_nettype none
module iss_pair_buffer (
	input wire logic clk,
	input wire logic nrst,
	input wire logic in_valid,
	output logic in_ready,
	input wire iss_pkg::iss_word_t in_word,
	output logic out_valid,
	input wire logic out_ready,
	output iss_pkg::iss_word_t out_word
);
	iss_pkg::iss_word_t slot_reg [2];
	logic wr_ptr_reg;
	logic rd_ptr_reg;
	logic [1:0] count_reg;
	logic push;
	logic pop;

	// Full and empty come straight from the fill count
	assign in_ready = count_reg != iss_pkg::BUF_DEPTH;
	assign out_valid = count_reg != 2'h0;
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_word = slot_reg[rd_ptr_reg];

	// Pointers and fill count
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wr_ptr_reg <= 1'b0;
			rd_ptr_reg <= 1'b0;
			count_reg <= 2'h0;
		end else begin
			if (push)
				wr_ptr_reg <= ~wr_ptr_reg;
			if (pop)
				rd_ptr_reg <= ~rd_ptr_reg;
			if (push && !pop)
				count_reg <= count_reg + 2'h1;
			else if (pop && !push)
				count_reg <= count_reg - 2'h1;
		end
	end

	// Storage, cleared so the output is defined from reset
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			slot_reg[0] <= '0;
			slot_reg[1] <= '0;
		end else if (push) begin
			slot_reg[wr_ptr_reg] <= in_word;
		end
	end
endmodule
`default_nettype wire

// ---- verification/iss_cam_model.sv ----
// Camera controller model: configuration, exposure pins and receiver
`default_nettype none
module iss_cam_model (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [1:0] rx_mode,
	output logic sequencer_restart_low,
	output logic cfg_load,
	output iss_pkg::iss_cfg_t cfg_in,
	output logic exposure_1,
	output logic exposure_2,
	output logic out_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	// Pixels stay in reset 3 us after release, so no early exposure
	localparam int PIX_RESET_CLKS = 3000 / iss_pkg::CLK_PERIOD_NS + 1;
	localparam int SEQ_RESET_CLKS = 20;
	localparam int EXP_HOLD_CLKS = 16;

	// Quiet pins at time zero
	initial begin
		sequencer_restart_low = 1'b1;
		cfg_load = 1'b0;
		cfg_in = iss_pkg::CFG_RESET;
		exposure_1 = 1'b0;
		exposure_2 = 1'b0;
	end

	// Receiver: 0 always ready, 1 random stalls, other values stopped
	always @(posedge clk) begin
		if (rx_mode == 2'h0)
			out_ready <= 1'b1;
		else
			out_ready <= (rx_mode == 2'h1) && ($urandom_range(0, 3) != 0);
	end

	// Upload with the sequencer held in reset, held long enough
	task automatic upload(input iss_pkg::iss_cfg_t c);
		@(posedge clk);
		sequencer_restart_low <= 1'b0;
		cfg_load <= 1'b1;
		cfg_in <= c;
		@(posedge clk);
		cfg_load <= 1'b0;
		repeat (SEQ_RESET_CLKS) @(posedge clk);
	endtask

	// Release the sequencer, then let the pixels settle in reset
	task automatic release_seq();
		@(posedge clk);
		sequencer_restart_low <= 1'b1;
		repeat (PIX_RESET_CLKS) @(posedge clk);
	endtask

	// Short sequencer reset pulse
	task automatic seq_pulse();
		@(posedge clk);
		sequencer_restart_low <= 1'b0;
		repeat (SEQ_RESET_CLKS) @(posedge clk);
		sequencer_restart_low <= 1'b1;
	endtask

	// Fresh exposure with a second slope; levels held past the deglitch
	task automatic expose(input int len);
		@(posedge clk);
		exposure_1 <= 1'b1;
		repeat (len) @(posedge clk);
		exposure_2 <= 1'b1;
		repeat (EXP_HOLD_CLKS) @(posedge clk);
		exposure_1 <= 1'b0;
		repeat (EXP_HOLD_CLKS) @(posedge clk);
		exposure_2 <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ---- verification/iss_control_bench.sv ----
// Self-checking bench of the sequencer control
`default_nettype none
module iss_control_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, nrst, seq_low, cfg_load, exp1, exp2, out_ready, out_valid;
	logic fov_ind, row_ind, pix_rst, ds_rst, running;
	logic [1:0] rx_mode;
	iss_pkg::iss_cfg_t cfg_in, cfg_active, cfg;
	iss_pkg::iss_word_t out_word;
	iss_pkg::iss_word_t got_q[$];
	int err_count, checked, n, rlen;

	iss_control dut (.clk(clk), .nrst(nrst),
		.sequencer_restart_low(seq_low), .cfg_load(cfg_load),
		.cfg_in(cfg_in), .exposure_1(exp1), .exposure_2(exp2),
		.out_ready(out_ready), .out_valid(out_valid), .out_word(out_word),
		.frame_overhead_indicator(fov_ind), .row_overhead_indicator(row_ind),
		.pixel_reset(pix_rst), .dual_slope_reset(ds_rst),
		.sequencer_running(running), .cfg_active(cfg_active));
	iss_cam_model cam (.clk(clk), .nrst(nrst), .rx_mode(rx_mode),
		.sequencer_restart_low(seq_low), .cfg_load(cfg_load),
		.cfg_in(cfg_in), .exposure_1(exp1), .exposure_2(exp2),
		.out_ready(out_ready));

	// Clock, 8 ns period
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// Keep every word the receiver takes
	always @(posedge clk) begin
		if (nrst === 1'b1 && out_valid === 1'b1 && out_ready === 1'b1)
			got_q.push_back(out_word);
	end

	task automatic final_report();
		if (err_count == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic check_val(input string nm, input logic [127:0] e,
		input logic [127:0] g);
		checked++;
		if (g !== e) begin
			err_count++;
			$display("wrong value %s expected %0h seen %0h", nm, e, g);
		end
	endtask
`define CHECK(nm, e, g) check_val(nm, 128'(e), 128'(g))

	function automatic logic sel(input int w);
		return (w == 0) ? fov_ind : (w == 1) ? row_ind : running;
	endfunction

	// Bounded wait for a level; n holds the cycles spent
	task automatic wait_for(input int w, input logic lvl, input int bound);
		n = 0;
		while (sel(w) !== lvl) begin
			if (n >= bound) begin
				err_count++;
				final_report();
			end
			@(posedge clk);
			#1;
			n++;
		end
	endtask

	function automatic int data_words();
		int c;
		c = 0;
		foreach (got_q[i]) c += int'(got_q[i].kind[1]);
		return c;
	endfunction

	function automatic logic [15:0] pix_val(input iss_pkg::iss_cfg_t c,
		input int k);
		return 16'(c.window_kernel_start | 6'h01) + 16'(k);
	endfunction

	// Random window within the limits the controller keeps
	function automatic iss_pkg::iss_cfg_t rand_cfg();
		iss_pkg::iss_cfg_t c;
		c = iss_pkg::CFG_RESET;
		c.window_kernel_start = 6'(2 * $urandom_range(0, 20) + 1);
		c.window_kernel_count = 6'($urandom_range(4, 9));
		// Odd count keeps the minimum row length, even count adds one
		c.row_overhead_length = 8'(iss_pkg::REDUCED_ROW_OVH_CYCLES) +
			8'(!c.window_kernel_count[0]);
		c.line_first = 11'($urandom_range(0, 1700));
		c.line_last = c.line_first + 11'($urandom_range(0, 2));
		c.frame_ovh_length = 10'($urandom_range(3, 12));
		c.idle_a = 16'($urandom);
		c.idle_b = 16'($urandom);
		return c;
	endfunction

	// Idle words must alternate with nothing lost across stalls
	task automatic check_idle(input logic [15:0] a, input logic [15:0] b);
		`CHECK("idle seen", 1, got_q.size() > 0);
		foreach (got_q[i]) begin
			`CHECK("idle value", got_q[i].kind[0] ? b : a, got_q[i].value);
			if (i > 0)
				`CHECK("idle order", {1'b0, ~got_q[i-1].kind[0]}, got_q[i].kind);
		end
	endtask

	// Window readout: per line a line word then the kernel words
	task automatic check_frame(input iss_pkg::iss_cfg_t c);
		iss_pkg::iss_word_t w[$];
		int per, lines, k;
		iss_pkg::iss_word_t lw;
		per = c.window_kernel_count + 1;
		lines = c.line_last - c.line_first + 1;
		for (k = 0; data_words() < per * lines; k++) begin
			if (k > 20000) begin
				err_count++;
				final_report();
			end
			@(posedge clk);
		end
		repeat (per * 8) @(posedge clk);
		foreach (got_q[i]) if (got_q[i].kind[1]) w.push_back(got_q[i]);
		`CHECK("word count", per * lines, w.size());
		foreach (w[i]) begin
			k = i % per;
			if (k == 0) begin
				lw = {iss_pkg::KIND_LINE, 16'(c.line_first) + 16'(i / per)};
				`CHECK("line word", lw, w[i]);
			end else
				`CHECK("pixel word", {iss_pkg::KIND_PIXEL, pix_val(c, k - 1)}, w[i]);
		end
	endtask

	// Main sequence
	initial begin
		void'($urandom(63559));
		nrst = 1'b0;
		rx_mode = 2'h2;
		err_count = 0;
		checked = 0;
		repeat (4) @(posedge clk);
		#1;
		`CHECK("valid in reset", 0, out_valid);
		`CHECK("pixels in reset", 1, pix_rst);
		`CHECK("config in reset", iss_pkg::CFG_RESET, cfg_active);
		`CHECK("reduced row", 9, cfg_active.row_overhead_length);
		@(posedge clk);
		nrst <= 1'b1;
		// Receiver stopped so the buffer fills, then random stalls
		n = 0;
		while (running !== 1'b1 && n < 200) begin
			@(posedge clk);
			#1;
			n++;
			if (n == 30) begin
				`CHECK("held word", 1, out_valid);
				rx_mode <= 2'h1;
			end
		end
		`CHECK("sequencer hold", iss_pkg::SEQ_HOLD_CYCLES + 1, n);
		if (running !== 1'b1)
			final_report();
		check_idle(iss_pkg::IDLE_A_RESET, iss_pkg::IDLE_B_RESET);
		for (int f = 0; f < 2; f++) begin
			cfg = rand_cfg();
			// First frame: narrowest window on the last line, reduced rows
			if (f == 0) begin
				cfg.line_first = 11'h6ad;
				cfg.line_last = 11'h6ad;
				cfg.window_kernel_count = 6'h04;
				cfg.row_overhead_length = 8'h0a;
			end else begin
				cfg.reduced_row_ovh = 1'b0;
			end
			rlen = cfg.reduced_row_ovh ? iss_pkg::REDUCED_ROW_OVH_CYCLES :
				int'(cfg.row_overhead_length);
			cam.upload(cfg);
			#1;
			`CHECK("config loaded", cfg, cfg_active);
			`CHECK("seq held", 0, running);
			cam.release_seq();
			got_q.delete();
			fork
				cam.expose(20);
			join_none
			wait_for(0, 1'b1, 2000);
			`CHECK("exposure began", 0, pix_rst);
			`CHECK("dual slope on", 1, ds_rst);
			wait_for(0, 1'b0, 2000);
			`CHECK("frame ind", (cfg.frame_ovh_length - 1) * 4, n);
			wait_for(1, 1'b1, 100);
			`CHECK("row start", 4, n);
			wait_for(1, 1'b0, 100);
			`CHECK("row ind", (rlen - 1) * 4, n);
			check_frame(cfg);
			`CHECK("pixels rearmed", 1, pix_rst);
			`CHECK("dual slope off", 0, ds_rst);
		end
		// Sequencer reset keeps the configuration
		fork
			cam.seq_pulse();
		join_none
		repeat (8) @(posedge clk);
		#1;
		`CHECK("seq reset run", 0, running);
		`CHECK("seq reset pixels", 1, pix_rst);
		`CHECK("seq reset config", cfg, cfg_active);
		got_q.delete();
		repeat (10) @(posedge clk);
		check_idle(cfg.idle_a, cfg.idle_b);
		repeat (20) @(posedge clk);
		nrst <= 1'b0;
		@(posedge clk);
		#1;
		`CHECK("chip reset config", iss_pkg::CFG_RESET, cfg_active);
		`CHECK("chip reset valid", 0, out_valid);
		final_report();
	end
endmodule
`default_nettype wire
